/* File: prt_port_regs.sv */
// port control register bank: direction, data latch and analog select
// assumes a byte-wide processor bus on this clock and pins from outside
`timescale 1ns/100ps

// Functional notes
// [R1] direction bit 0 turns the pin driver on, 1 leaves the pin as input
// [R2] reset loads every direction register with all ones
// [R3] direction registers sit at FF22H, FF23H, FF24H, read and write
// [R4] data latch registers sit at FF02H, FF03H, FF04H
// [R5] data read gives pin level for inputs, latch value for outputs
// [R6] latch 0 drives low, 1 drives high; input low reads 0, high 1
// [R7] reset clears all output latches
// [R8] port-3 reset-shared pin bit is read-only and shows the pin level
// [R9] direction registers take bit writes and byte writes
// [R10] analog select at FF84H, bits 0-3, 1 selects analog input
// [R11] reset clears analog select, port-2 pins start digital
// [R12] analog-selected pin loses digital function, routed to converter; external_interrupt_0 still follows the port-2 bit 1 pin level
// [R13] software keeps pull-up off on analog-selected pins
// [R14] interrupt-shared pins feed their detectors in output mode too
// [R15] software masks the interrupt before using its pin as output
// [R16] software sets direction, latch and analog bits for alternate use
// [R17] missing direction bits read 1, missing data/analog bits read 0
// [R18] latch write in input mode stores but leaves the pin undriven
// [R19] bit operation on a port is an eight-bit read-modify-write
module prt_port_regs (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire prt_pkg::prt_bus_req_t bus_req,
  output logic      [7:0]       cpu_rdata,
  output logic                  cpu_rvalid,
  input  wire prt_pkg::prt_pins_t pin_in,
  output prt_pkg::prt_pins_t    pin_out,
  output prt_pkg::prt_pins_t    pin_oe,
  output logic      [3:0]       analog_route,
  output logic                  external_interrupt_0,
  output logic                  external_interrupt_1
);

  prt_pkg::prt_pins_t pin_sync;

  logic [7:0] port2_data_latch;
  logic [7:0] port3_data_latch;
  logic [7:0] port4_data_latch;
  logic [7:0] port2_direction;
  logic [7:0] port3_direction;
  logic [7:0] port4_direction;
  logic [7:0] port2_analog_select;

  logic [7:0] next_port2_data_latch;
  logic [7:0] next_port3_data_latch;
  logic [7:0] next_port4_data_latch;
  logic [7:0] next_port2_direction;
  logic [7:0] next_port3_direction;
  logic [7:0] next_port4_direction;
  logic [7:0] next_port2_analog_select;
  logic [7:0] next_cpu_rdata;
  logic       next_cpu_rvalid;
  prt_pkg::prt_pins_t next_pin_out;
  prt_pkg::prt_pins_t next_pin_oe;
  logic [3:0] next_analog_route;
  logic       next_external_interrupt_0;
  logic       next_external_interrupt_1;

  prt_pkg::prt_sel_t sel;
  logic [7:0]        cur_value;
  logic [7:0]        wr_value;
  logic [7:0]        p2_pins;
  logic [7:0]        p3_pins;
  logic [7:0]        p2_read;
  logic [7:0]        p3_read;
  logic [7:0]        p4_read;

  prt_sync #(
    .WIDTH ($bits(prt_pkg::prt_pins_t))
  ) u_sync (
    .clock    (clock),
    .rst      (rst),
    .async_in (pin_in),
    .sync_out (pin_sync)
  );

  // [R3] [R4] [R10] address decode
  function automatic prt_pkg::prt_sel_t decode(input logic [15:0] addr);
    unique case (addr)
      prt_pkg::PRT_ADDR_DATA2:   decode = prt_pkg::PRT_SEL_DATA2;
      prt_pkg::PRT_ADDR_DATA3:   decode = prt_pkg::PRT_SEL_DATA3;
      prt_pkg::PRT_ADDR_DATA4:   decode = prt_pkg::PRT_SEL_DATA4;
      prt_pkg::PRT_ADDR_DIR2:    decode = prt_pkg::PRT_SEL_DIR2;
      prt_pkg::PRT_ADDR_DIR3:    decode = prt_pkg::PRT_SEL_DIR3;
      prt_pkg::PRT_ADDR_DIR4:    decode = prt_pkg::PRT_SEL_DIR4;
      prt_pkg::PRT_ADDR_ANALOG2: decode = prt_pkg::PRT_SEL_ANALOG2;
      default:                   decode = prt_pkg::PRT_SEL_NONE;
    endcase
  endfunction

  // [R5] [R6] per-bit pin level or latch by direction
  function automatic logic [7:0] port_read(
    input logic [7:0] latch,
    input logic [7:0] dir,
    input logic [7:0] pins,
    input logic [7:0] mask
  );
    port_read = ((dir & pins) | (~dir & latch)) & mask;
  endfunction

  // [R17] unimplemented bits held at fixed fill
  function automatic logic [7:0] masked(
    input logic [7:0] value,
    input logic [7:0] mask,
    input logic [7:0] fill
  );
    masked = (value & mask) | (fill & ~mask);
  endfunction

  always_comb begin
    p2_pins = {4'h0, pin_sync.p2};
    p3_pins = 8'h00;
    p3_pins[prt_pkg::PRT_P3_IO_BIT] = pin_sync.p3_2;

    // [R12] analog pins read no digital level
    p2_read = port_read(port2_data_latch, port2_direction, p2_pins,
                        prt_pkg::PRT_MASK_PORT2) & ~port2_analog_select;
    p3_read = port_read(port3_data_latch, port3_direction, p3_pins,
                        prt_pkg::PRT_MASK_PORT3);
    // [R8] reset-shared pin read straight from the pin
    p3_read[prt_pkg::PRT_P3_RESET_BIT] = pin_sync.p3_4;
    p4_read = port_read(port4_data_latch, port4_direction, pin_sync.p4,
                        prt_pkg::PRT_MASK_PORT4);

    sel = decode(bus_req.addr);
    unique case (sel)
      prt_pkg::PRT_SEL_DATA2:   cur_value = p2_read;
      prt_pkg::PRT_SEL_DATA3:   cur_value = p3_read;
      prt_pkg::PRT_SEL_DATA4:   cur_value = p4_read;
      prt_pkg::PRT_SEL_DIR2:    cur_value = port2_direction;
      prt_pkg::PRT_SEL_DIR3:    cur_value = port3_direction;
      prt_pkg::PRT_SEL_DIR4:    cur_value = port4_direction;
      prt_pkg::PRT_SEL_ANALOG2: cur_value = port2_analog_select;
      prt_pkg::PRT_SEL_NONE:    cur_value = prt_pkg::PRT_READ_UNMAPPED;
    endcase

    // [R9] [R19] bit operation as byte read-modify-write
    wr_value = bus_req.wdata;
    if (bus_req.bit_op) begin
      wr_value = cur_value;
      wr_value[bus_req.bit_sel] = bus_req.bit_value;
    end

    next_port2_data_latch    = port2_data_latch;
    next_port3_data_latch    = port3_data_latch;
    next_port4_data_latch    = port4_data_latch;
    next_port2_direction     = port2_direction;
    next_port3_direction     = port3_direction;
    next_port4_direction     = port4_direction;
    next_port2_analog_select = port2_analog_select;

    // [R18] latch writes land regardless of direction
    if (bus_req.wr) begin
      unique case (sel)
        prt_pkg::PRT_SEL_DATA2: next_port2_data_latch =
          masked(wr_value, prt_pkg::PRT_MASK_PORT2, 8'h00);
        prt_pkg::PRT_SEL_DATA3: next_port3_data_latch =
          masked(wr_value, prt_pkg::PRT_MASK_PORT3, 8'h00);
        prt_pkg::PRT_SEL_DATA4: next_port4_data_latch =
          masked(wr_value, prt_pkg::PRT_MASK_PORT4, 8'h00);
        prt_pkg::PRT_SEL_DIR2: next_port2_direction =
          masked(wr_value, prt_pkg::PRT_MASK_PORT2, 8'hFF);
        prt_pkg::PRT_SEL_DIR3: next_port3_direction =
          masked(wr_value, prt_pkg::PRT_MASK_PORT3, 8'hFF);
        prt_pkg::PRT_SEL_DIR4: next_port4_direction =
          masked(wr_value, prt_pkg::PRT_MASK_PORT4, 8'hFF);
        prt_pkg::PRT_SEL_ANALOG2: next_port2_analog_select =
          masked(wr_value, prt_pkg::PRT_MASK_ANALOG2, 8'h00);
        prt_pkg::PRT_SEL_NONE: ;
      endcase
    end

    next_cpu_rvalid = bus_req.rd;
    next_cpu_rdata  = bus_req.rd ? cur_value : cpu_rdata;

    // [R1] [R6] [R12] drivers follow next register state
    next_pin_out.p2   = next_port2_data_latch[3:0];
    next_pin_oe.p2    = ~next_port2_direction[3:0] & ~next_port2_analog_select[3:0];
    next_pin_out.p3_2 = next_port3_data_latch[prt_pkg::PRT_P3_IO_BIT];
    next_pin_oe.p3_2  = ~next_port3_direction[prt_pkg::PRT_P3_IO_BIT];
    next_pin_out.p3_4 = 1'b0;
    next_pin_oe.p3_4  = 1'b0;
    next_pin_out.p4   = next_port4_data_latch;
    next_pin_oe.p4    = ~next_port4_direction;
    next_analog_route = next_port2_analog_select[3:0];

    // [R14] detectors see the driven level in output mode
    next_external_interrupt_0 = pin_oe.p2[prt_pkg::PRT_P2_INT_BIT]
                              ? pin_out.p2[prt_pkg::PRT_P2_INT_BIT]
                              : pin_sync.p2[prt_pkg::PRT_P2_INT_BIT];
    next_external_interrupt_1 = pin_oe.p3_2 ? pin_out.p3_2 : pin_sync.p3_2;
  end

  // [R2] [R7] [R11] reset values
  always_ff @(posedge clock) begin
    if (rst) begin
      port2_data_latch     <= prt_pkg::PRT_RESET_DATA;
      port3_data_latch     <= prt_pkg::PRT_RESET_DATA;
      port4_data_latch     <= prt_pkg::PRT_RESET_DATA;
      port2_direction      <= prt_pkg::PRT_RESET_DIR;
      port3_direction      <= prt_pkg::PRT_RESET_DIR;
      port4_direction      <= prt_pkg::PRT_RESET_DIR;
      port2_analog_select  <= prt_pkg::PRT_RESET_ANALOG;
      cpu_rdata            <= prt_pkg::PRT_READ_UNMAPPED;
      cpu_rvalid           <= 1'b0;
      pin_out              <= '0;
      pin_oe               <= '0;
      analog_route         <= 4'h0;
      external_interrupt_0 <= 1'b0;
      external_interrupt_1 <= 1'b0;
    end else begin
      port2_data_latch     <= next_port2_data_latch;
      port3_data_latch     <= next_port3_data_latch;
      port4_data_latch     <= next_port4_data_latch;
      port2_direction      <= next_port2_direction;
      port3_direction      <= next_port3_direction;
      port4_direction      <= next_port4_direction;
      port2_analog_select  <= next_port2_analog_select;
      cpu_rdata            <= next_cpu_rdata;
      cpu_rvalid           <= next_cpu_rvalid;
      pin_out              <= next_pin_out;
      pin_oe               <= next_pin_oe;
      analog_route         <= next_analog_route;
      external_interrupt_0 <= next_external_interrupt_0;
      external_interrupt_1 <= next_external_interrupt_1;
    end
  end

endmodule

/* File: prt_pkg.sv */
// constants and carriers for the port control register bank
// assumes one system clock, byte-wide internal processor bus
package prt_pkg;

  localparam logic [15:0] PRT_ADDR_DATA2   = 16'hFF02;
  localparam logic [15:0] PRT_ADDR_DATA3   = 16'hFF03;
  localparam logic [15:0] PRT_ADDR_DATA4   = 16'hFF04;
  localparam logic [15:0] PRT_ADDR_DIR2    = 16'hFF22;
  localparam logic [15:0] PRT_ADDR_DIR3    = 16'hFF23;
  localparam logic [15:0] PRT_ADDR_DIR4    = 16'hFF24;
  localparam logic [15:0] PRT_ADDR_ANALOG2 = 16'hFF84;

  localparam logic [7:0] PRT_RESET_DIR    = 8'hFF;
  localparam logic [7:0] PRT_RESET_DATA   = 8'h00;
  localparam logic [7:0] PRT_RESET_ANALOG = 8'h00;
  localparam logic [7:0] PRT_READ_UNMAPPED = 8'h00;

  // implemented bit positions per register
  localparam logic [7:0] PRT_MASK_PORT2   = 8'h0F;
  localparam logic [7:0] PRT_MASK_PORT3   = 8'h04;
  localparam logic [7:0] PRT_MASK_PORT4   = 8'hFF;
  localparam logic [7:0] PRT_MASK_ANALOG2 = 8'h0F;

  // bit positions of special pins
  localparam int PRT_P3_IO_BIT    = 2;
  localparam int PRT_P3_RESET_BIT = 4;
  localparam int PRT_P2_INT_BIT   = 1;

  localparam int PRT_SYNC_STAGES = 2;

  typedef enum logic [2:0] {
    PRT_SEL_NONE,
    PRT_SEL_DATA2,
    PRT_SEL_DATA3,
    PRT_SEL_DATA4,
    PRT_SEL_DIR2,
    PRT_SEL_DIR3,
    PRT_SEL_DIR4,
    PRT_SEL_ANALOG2
  } prt_sel_t;

  typedef struct packed {
    logic [15:0] addr;
    logic        wr;
    logic        rd;
    logic        bit_op;
    logic [2:0]  bit_sel;
    logic        bit_value;
    logic [7:0]  wdata;
  } prt_bus_req_t;

  typedef struct packed {
    logic [7:0] p4;
    logic       p3_4;
    logic       p3_2;
    logic [3:0] p2;
  } prt_pins_t;

endpackage

/* File: prt_sync.sv */
// two-flop synchroniser for asynchronous pin levels
// assumes inputs come from outside the clock domain
`timescale 1ns/100ps

module prt_sync #(
  parameter int WIDTH = 14
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_sync_out;

  if (WIDTH < 1) begin : g_chk
    $error("prt_sync: WIDTH must be at least 1");
  end

  // first stage is read only by the second
  always_comb begin
    next_stage1   = async_in;
    next_sync_out = stage1;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= next_stage1;
      sync_out <= next_sync_out;
    end
  end

endmodule

/* File: prt_pin_model.sv */
// external devices on the port pins, seen as pin levels
// assumes pins are driven by the block when enabled, else by the bench
`timescale 1ns/100ps

module prt_pin_model (
  input  wire prt_pkg::prt_pins_t pin_out,
  input  wire prt_pkg::prt_pins_t pin_oe,
  input  wire prt_pkg::prt_pins_t ext,
  output prt_pkg::prt_pins_t      pin_in
);
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule

/* File: prt_port_regs_asserts.sv */
// checker for the port control register bank
// assumes it sees only the ports of prt_port_regs
`timescale 1ns/100ps

module prt_port_regs_asserts (
  input wire logic                  clock,
  input wire logic                  rst,
  input wire prt_pkg::prt_bus_req_t bus_req,
  input wire logic [7:0]            cpu_rdata,
  input wire logic                  cpu_rvalid,
  input wire prt_pkg::prt_pins_t    pin_in,
  input wire prt_pkg::prt_pins_t    pin_out,
  input wire prt_pkg::prt_pins_t    pin_oe,
  input wire logic [3:0]            analog_route,
  input wire logic                  external_interrupt_0,
  input wire logic                  external_interrupt_1
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_byte_wr(logic [15:0] a);
    bus_req.wr && !bus_req.bit_op && bus_req.addr == a;
  endsequence
  a_reset_state: assert property ($fell(rst) |-> pin_oe == '0 && analog_route == 4'h0)
    else $error("outputs not cleared by reset");
  a_read_answer: assert property (bus_req.rd |=> cpu_rvalid)
    else $error("read not answered");
  a_no_spurious: assert property (cpu_rvalid |-> $past(bus_req.rd))
    else $error("read answer without request");
  a_unmapped_zero: assert property (bus_req.rd && bus_req.addr == 16'hFF05 |=> cpu_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_dir4_drive: assert property (s_byte_wr(16'hFF24) |=> pin_oe.p4 == ~$past(bus_req.wdata))
    else $error("direction write not applied");
  a_latch4_level: assert property (s_byte_wr(16'hFF04) |=>
    ((pin_out.p4 ^ $past(bus_req.wdata)) & pin_oe.p4) == 8'h00)
    else $error("driven level differs from latch");
  a_analog_route: assert property (s_byte_wr(16'hFF84) |=> analog_route == $past(bus_req.wdata[3:0]))
    else $error("analog select not applied");
  a_analog_off: assert property ((pin_oe.p2 & analog_route) == 4'h0)
    else $error("analog pin still driven");
  a_reset_pin_in: assert property (pin_oe.p3_4 == 1'b0)
    else $error("input-only pin driven");
  a_reset_pin_read: assert property (bus_req.rd && bus_req.addr == 16'hFF03 |=>
    cpu_rdata[4] == $past(pin_in.p3_4, 3))
    else $error("input-only pin level not read");
endmodule

bind prt_port_regs prt_port_regs_asserts i_prt_port_regs_asserts (.clock(clock), .rst(rst),
  .bus_req(bus_req), .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid), .pin_in(pin_in),
  .pin_out(pin_out), .pin_oe(pin_oe), .analog_route(analog_route),
  .external_interrupt_0(external_interrupt_0), .external_interrupt_1(external_interrupt_1));

/* File: tb_prt_port_regs.sv */
// self-checking bench for the port control register bank
// assumes prt_pkg, prt_pin_model and the checker are compiled first
`timescale 1ns/100ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end

module tb_prt_port_regs;
  logic                  clock;
  logic                  rst;
  logic                  cpu_rvalid;
  logic                  external_interrupt_0;
  logic                  external_interrupt_1;
  logic [7:0]            cpu_rdata;
  logic [7:0]            rdat;
  logic [3:0]            analog_route;
  prt_pkg::prt_bus_req_t bus_req;
  prt_pkg::prt_pins_t    pin_in;
  prt_pkg::prt_pins_t    pin_out;
  prt_pkg::prt_pins_t    pin_oe;
  prt_pkg::prt_pins_t    ext;
  int                    err_count = 0;
  int                    checked = 0;

  prt_port_regs i_prt_port_regs (.clock(clock), .rst(rst), .bus_req(bus_req),
    .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .analog_route(analog_route),
    .external_interrupt_0(external_interrupt_0), .external_interrupt_1(external_interrupt_1));
  prt_pin_model i_prt_pin_model (.pin_out(pin_out), .pin_oe(pin_oe), .ext(ext), .pin_in(pin_in));

  task automatic req(input logic [15:0] a, input logic w, input logic b, input logic [2:0] s,
                     input logic [7:0] d);
    @(posedge clock);
    #1;
    bus_req = '{addr: a, wr: w, rd: !w, bit_op: b, bit_sel: s, bit_value: d[0], wdata: d};
    @(posedge clock);
    #1;
    if (!w) `CHK(cpu_rvalid, 1'b1)
    rdat = cpu_rdata;
    bus_req = '0;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    req(a, 1'b1, 1'b0, 3'h0, d);
  endtask
  task automatic bw(input logic [15:0] a, input logic [2:0] s, input logic v);
    req(a, 1'b1, 1'b1, s, {7'h00, v});
  endtask
  task automatic rchk(input logic [15:0] a, input logic [7:0] e);
    req(a, 1'b0, 1'b0, 3'h0, 8'h00);
    `CHK(rdat, e)
  endtask

  task automatic t_reset;
    logic [15:0] a [7] = '{16'hFF22, 16'hFF23, 16'hFF24, 16'hFF84, 16'hFF02, 16'hFF03, 16'hFF04};
    logic [7:0]  e [7] = '{8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
    `CHK(pin_oe, 14'h0000)
    for (int i = 0; i < 7; i++) begin
      rchk(a[i], e[i]);
    end
  endtask
  task automatic t_port4;
    wr(16'hFF24, 8'h00);
    `CHK({pin_oe.p4, pin_out.p4}, 16'hFF00)
    wr(16'hFF04, 8'hA5);
    rchk(16'hFF04, 8'hA5);
    ext.p4 = 8'h3C;
    wr(16'hFF24, 8'hFF);
    wr(16'hFF04, 8'h0F);
    `CHK(pin_oe.p4, 8'h00)
    rchk(16'hFF04, 8'h3C);
    bw(16'hFF04, 3'h0, 1'b1);
    wr(16'hFF24, 8'h00);
    `CHK(pin_out.p4, 8'h3D)
  endtask
  task automatic t_dir;
    wr(16'hFF22, 8'h00);
    rchk(16'hFF22, 8'hF0);
    bw(16'hFF22, 3'h1, 1'b1);
    rchk(16'hFF22, 8'hF2);
    `CHK(pin_oe.p2, 4'hD)
    wr(16'hFF23, 8'h00);
    rchk(16'hFF23, 8'hFB);
  endtask
  // analog pins left at direction F2 with bits 0, 2, 3 as outputs, no pull-up in this bench
  task automatic t_analog;
    wr(16'hFF84, 8'hFF);
    rchk(16'hFF84, 8'h0F);
    `CHK({analog_route, pin_oe.p2}, 8'hF0)
    wr(16'hFF84, 8'h00);
  endtask
  // interrupt mask is outside this block, taken as set
  task automatic t_irq;
    bw(16'hFF22, 3'h1, 1'b0);
    wr(16'hFF02, 8'h02);
    wr(16'hFF03, 8'h04);
    repeat (4) @(posedge clock);
    `CHK({external_interrupt_0, external_interrupt_1}, 2'h3)
    ext.p3_4 = 1'b1;
    wr(16'hFF03, 8'h00);
    rchk(16'hFF03, 8'h10);
    rchk(16'hFF05, 8'h00);
  endtask
  task automatic t_rst2;
    @(posedge clock);
    #1;
    rst = 1'b1;
    repeat (3) @(posedge clock);
    #1;
    rst = 1'b0;
    `CHK({pin_oe, analog_route}, 18'h00000)
    rchk(16'hFF24, 8'hFF);
    rchk(16'hFF84, 8'h00);
    ext.p2 = 4'h2;
    ext.p3_2 = 1'b1;
    repeat (4) @(posedge clock);
    `CHK({external_interrupt_0, external_interrupt_1}, 2'h3)
    wr(16'hFF24, 8'h00);
    `CHK(pin_out.p4, 8'h00)
  endtask

  task automatic stop_test;
    $display("checks=%0d errors=%0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  initial begin
    rst = 1'b1;
    bus_req = '0;
    ext = '0;
    repeat (6) @(posedge clock);
    #1;
    rst = 1'b0;
    t_reset;
    t_port4;
    t_dir;
    t_analog;
    t_irq;
    t_rst2;
    stop_test;
  end
  initial begin
    #20000;
    err_count++;
    stop_test;
  end
endmodule
